// ==== hw/mdsr_top.sv ====
// The strobed register port was decided locally.
module mdsr_top (
  input  wire logic                      core_clk,
  input  wire logic                      arst_n,
  input  wire logic                      clk_en,
  input  wire logic [7:0]                addr,
  input  wire logic [31:0]               wdata,
  input  wire logic                      wr_stb,
  input  wire logic                      rd_stb,
  output logic      [31:0]               rdata,
  input  wire mdsr_pkg::mdsr_mac_in_type mac_in,
  input  wire mdsr_pkg::mdsr_pin_in_type pin_in,
  output logic                           speed_detect_start,
  output logic                           irq
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  mdsr_pkg::mdsr_pin_in_type pin_s;

  mdsr_sync #(
    .W ($bits(mdsr_pkg::mdsr_pin_in_type))
  ) u_pin_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .clk_en   (clk_en),
    .d        (pin_in),
    .q        (pin_s)
  );

  // ----------------------------------------------------------------
  // Software control registers
  // ----------------------------------------------------------------
  logic [7:0]  ctrl_r;
  logic        wr_ctrl;
  logic        wr_ext;
  logic        wr_ists;
  logic        wr_imask;

  assign wr_ctrl  = wr_stb && (addr == mdsr_pkg::ADDR_CTRL);
  assign wr_ext   = wr_stb && (addr == mdsr_pkg::ADDR_EXT_CTRL);
  assign wr_ists  = wr_stb && (addr == mdsr_pkg::ADDR_IRQ_STATUS);
  assign wr_imask = wr_stb && (addr == mdsr_pkg::ADDR_IRQ_MASK);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= mdsr_pkg::CTRL_RESET;
    end else if (clk_en && wr_ctrl) begin
      ctrl_r <= wdata[7:0];
    end
  end

  // Kick is self clearing: a one-cycle start toward the detector
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      speed_detect_start <= 1'b0;
    end else if (clk_en) begin
      speed_detect_start <= wr_ext && wdata[mdsr_pkg::EXT_KICK];
    end
  end

  // ----------------------------------------------------------------
  // Mode and duplex
  // ----------------------------------------------------------------
  logic serdes_mode;
  logic duplex_r;

  // Variants without the select pin read serializer mode as zero
  assign serdes_mode = mdsr_pkg::HAS_SERDES & pin_s.serdes_sel;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      duplex_r <= 1'b0;
    end else if (clk_en) begin
      if (ctrl_r[mdsr_pkg::CTRL_FORCE_DUPLEX]) begin
        duplex_r <= ctrl_r[mdsr_pkg::CTRL_DUPLEX];
      end else begin
        duplex_r <= mac_in.an_duplex;
      end
    end
  end

  // ----------------------------------------------------------------
  // Link state
  // ----------------------------------------------------------------
  logic link_r;
  logic link_nxt;

  always_comb begin
    if (serdes_mode) begin
      if (ctrl_r[mdsr_pkg::CTRL_FORCE_LINK]) begin
        link_nxt = 1'b1;
      end else if (ctrl_r[mdsr_pkg::CTRL_AN_EN]) begin
        link_nxt = mac_in.an_link_ok;
      end else begin
        // Neither forced nor negotiated: no link to report
        link_nxt = 1'b0;
      end
    end else begin
      link_nxt = mac_in.phy_link;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      link_r <= 1'b0;
    end else if (clk_en) begin
      link_r <= link_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Configured speed
  // ----------------------------------------------------------------
  // Auto detection latches once per link-up so the MAC does not retune
  // mid-traffic if the PHY indication glitches.
  typedef enum logic [0:0] {
    MDSR_SPD_WAIT,
    MDSR_SPD_LOCKED
  } mdsr_spd_state_type;

  mdsr_spd_state_type spd_state_r;
  logic [1:0]         speed_r;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      spd_state_r <= MDSR_SPD_WAIT;
      speed_r     <= mdsr_pkg::SPEED_10;
    end else if (clk_en) begin
      if (ctrl_r[mdsr_pkg::CTRL_FORCE_SPEED]) begin
        speed_r     <= ctrl_r[mdsr_pkg::CTRL_SPEED +: 2];
        spd_state_r <= MDSR_SPD_WAIT;
      // Leaving auto mode re-arms the latch for the next link-up
      end else if (ctrl_r[mdsr_pkg::CTRL_ASD_EN]) begin
        case (spd_state_r)
          MDSR_SPD_WAIT: begin
            if (mac_in.phy_link) begin
              speed_r     <= mac_in.an_speed;
              spd_state_r <= MDSR_SPD_LOCKED;
            end
          end
          MDSR_SPD_LOCKED: begin
            if (!mac_in.phy_link) begin
              spd_state_r <= MDSR_SPD_WAIT;
            end
          end
          default: spd_state_r <= MDSR_SPD_WAIT;
        endcase
      end else begin
        speed_r     <= mac_in.phy_speed;
        spd_state_r <= MDSR_SPD_WAIT;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sensed speed
  // ----------------------------------------------------------------
  logic [1:0] sensed_r;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sensed_r <= mdsr_pkg::SPEED_10;
    end else if (clk_en && mac_in.sensed_valid) begin
      sensed_r <= mac_in.sensed_speed;
    end
  end

  // ----------------------------------------------------------------
  // Transmit pause
  // ----------------------------------------------------------------
  logic tx_paused_r;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_paused_r <= 1'b0;
    end else if (clk_en) begin
      if (!duplex_r || !mac_in.sym_fc_en) begin
        tx_paused_r <= 1'b0;
      end else if (mac_in.rx_xoff) begin
        tx_paused_r <= 1'b1;
      end else if (mac_in.rx_xon || mac_in.pause_expired) begin
        tx_paused_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  logic [31:0] status_word;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[mdsr_pkg::POS_DUPLEX]      = duplex_r;
    status_word[mdsr_pkg::POS_LINK]        = link_r;
    status_word[mdsr_pkg::POS_FUNC +: 2]   = mdsr_pkg::FUNC_ID;
    status_word[mdsr_pkg::POS_TXPAUSE]     = tx_paused_r;
    status_word[mdsr_pkg::POS_SERDES]      = serdes_mode;
    status_word[mdsr_pkg::POS_SPEED +: 2]  = speed_r;
    status_word[mdsr_pkg::POS_SENSED +: 2] = sensed_r;
    status_word[mdsr_pkg::POS_BUS66]       = pin_s.bus_66;
    status_word[mdsr_pkg::POS_WIDE]        = pin_s.req64;
    status_word[mdsr_pkg::POS_XMODE]       = pin_s.xmode;
    status_word[mdsr_pkg::POS_XSPEED +: 2] = pin_s.xspeed;
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [mdsr_pkg::IRQ_W-1:0] ists_r;
  logic [mdsr_pkg::IRQ_W-1:0] imask_r;
  logic [mdsr_pkg::IRQ_W-1:0] ev;
  logic                       link_d_r;
  logic                       pause_d_r;

  assign ev[mdsr_pkg::IRQ_LINK]   = link_r ^ link_d_r;
  assign ev[mdsr_pkg::IRQ_PAUSE]  = tx_paused_r & ~pause_d_r;
  assign ev[mdsr_pkg::IRQ_SENSED] = mac_in.sensed_valid;

  // Delay copies reset to the level of their sources, so no false event
  // appears in the first cycle after reset
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      link_d_r <= 1'h0;
    end else if (clk_en) begin
      link_d_r <= link_r;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pause_d_r <= 1'h0;
    end else if (clk_en) begin
      pause_d_r <= tx_paused_r;
    end
  end

  // A new event wins over a write-one clear in the same cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ists_r <= '0;
    end else if (clk_en) begin
      ists_r <= (ists_r & ~(wr_ists ? wdata[mdsr_pkg::IRQ_W-1:0] : '0)) | ev;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      imask_r <= '0;
    end else if (clk_en && wr_imask) begin
      imask_r <= wdata[mdsr_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(ists_r & imask_r);
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Status writes fall through: no write decode exists for that offset.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      rdata <= 32'h0000_0000;
      if (rd_stb) begin
        case (addr)
          mdsr_pkg::ADDR_DEVICE_STATUS: rdata <= status_word;
          mdsr_pkg::ADDR_CTRL:          rdata <= {24'h000000, ctrl_r};
          mdsr_pkg::ADDR_IRQ_STATUS:    rdata <= {29'h0, ists_r};
          mdsr_pkg::ADDR_IRQ_MASK:      rdata <= {29'h0, imask_r};
          // Extended control is write-only; its kick never reads back
          mdsr_pkg::ADDR_EXT_CTRL:      rdata <= 32'h0000_0000;
          default:                      rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// ==== hw/mdsr_pkg.sv ====
package mdsr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_DEVICE_STATUS = 8'h08;
  localparam logic [7:0]  ADDR_CTRL          = 8'h00;
  localparam logic [7:0]  ADDR_EXT_CTRL      = 8'h18;
  localparam logic [7:0]  ADDR_IRQ_STATUS    = 8'h20;
  localparam logic [7:0]  ADDR_IRQ_MASK      = 8'h24;

  // ----------------------------------------------------------------
  // Device status field positions
  // ----------------------------------------------------------------
  localparam int POS_DUPLEX   = 0;
  localparam int POS_LINK     = 1;
  localparam int POS_FUNC     = 2;
  localparam int POS_TXPAUSE  = 4;
  localparam int POS_SERDES   = 5;
  localparam int POS_SPEED    = 6;
  localparam int POS_SENSED   = 8;
  localparam int POS_BUS66    = 11;
  localparam int POS_WIDE     = 12;
  localparam int POS_XMODE    = 13;
  localparam int POS_XSPEED   = 14;

  // ----------------------------------------------------------------
  // Control register bits (own layout)
  // ----------------------------------------------------------------
  localparam int CTRL_FORCE_DUPLEX = 0;
  localparam int CTRL_DUPLEX       = 1;
  localparam int CTRL_ASD_EN       = 2;
  localparam int CTRL_FORCE_SPEED  = 3;
  localparam int CTRL_SPEED        = 4;
  localparam int CTRL_FORCE_LINK   = 6;
  localparam int CTRL_AN_EN        = 7;
  localparam int EXT_KICK          = 0;

  // ----------------------------------------------------------------
  // Interrupt causes
  // ----------------------------------------------------------------
  localparam int IRQ_LINK   = 0;
  localparam int IRQ_PAUSE  = 1;
  localparam int IRQ_SENSED = 2;
  localparam int IRQ_W      = 3;

  // ----------------------------------------------------------------
  // Reset values and variant options
  // ----------------------------------------------------------------
  localparam logic [7:0]       CTRL_RESET   = 8'h00;
  localparam logic [1:0]       SPEED_10     = 2'h0;
  localparam logic [1:0]       FUNC_ID      = 2'h0;
  localparam logic             HAS_SERDES   = 1'b1;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       an_link_ok;
    logic       phy_link;
    logic [1:0] phy_speed;
    logic [1:0] an_speed;
    logic       an_duplex;
    logic       rx_xoff;
    logic       rx_xon;
    logic       pause_expired;
    logic       sym_fc_en;
    logic [1:0] sensed_speed;
    logic       sensed_valid;
  } mdsr_mac_in_type;

  typedef struct packed {
    logic       serdes_sel;
    logic       bus_66;
    logic       req64;
    logic       xmode;
    logic [1:0] xspeed;
  } mdsr_pin_in_type;

endpackage

// ==== hw/mdsr_sync.sv ====
module mdsr_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // Two stage capture; the first stage feeds only the second
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else if (clk_en) begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

// ==== verification/mdsr_top_monitor.sv ====
module mdsr_top_monitor (
  input wire logic                      core_clk,
  input wire logic                      arst_n,
  input wire logic                      clk_en,
  input wire logic [7:0]                addr,
  input wire logic [31:0]               wdata,
  input wire logic                      wr_stb,
  input wire logic                      rd_stb,
  input wire logic [31:0]               rdata,
  input wire mdsr_pkg::mdsr_mac_in_type mac_in,
  input wire mdsr_pkg::mdsr_pin_in_type pin_in,
  input wire logic                      speed_detect_start,
  input wire logic                      irq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence s_rd_status;
    clk_en && rd_stb && addr == mdsr_pkg::ADDR_DEVICE_STATUS;
  endsequence
  // Pins pass a two-flop synchroniser, so they must sit still first
  sequence s_pins_quiet;
    $stable(pin_in) [*5];
  endsequence
  sequence s_kick;
    clk_en && wr_stb && addr == mdsr_pkg::ADDR_EXT_CTRL &&
    wdata[mdsr_pkg::EXT_KICK];
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_rsvd;
    s_rd_status |=> rdata[31:16] == 16'h0 && !rdata[10];
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved status bits not zero");
  property p_idle;
    clk_en && !rd_stb |=> rdata == 32'h0;
  endproperty
  a_idle: assert property (p_idle)
    else $error("read data shown without a read");
  property p_func;
    s_rd_status |=> rdata[3:2] == mdsr_pkg::FUNC_ID;
  endproperty
  a_func: assert property (p_func)
    else $error("function number wrong");
  property p_serdes;
    s_pins_quiet ##0 s_rd_status
      |=> rdata[5] == ($past(pin_in.serdes_sel) & mdsr_pkg::HAS_SERDES);
  endproperty
  a_serdes: assert property (p_serdes)
    else $error("serializer flag does not follow its pin");
  property p_bus66;
    s_pins_quiet ##0 s_rd_status |=> rdata[11] == $past(pin_in.bus_66);
  endproperty
  a_bus66: assert property (p_bus66)
    else $error("66 MHz flag does not follow its pin");
  property p_wide;
    s_pins_quiet ##0 s_rd_status |=> rdata[12] == $past(pin_in.req64);
  endproperty
  a_wide: assert property (p_wide)
    else $error("wide bus flag wrong");
  property p_xmode;
    s_pins_quiet ##0 s_rd_status |=> rdata[13] == $past(pin_in.xmode);
  endproperty
  a_xmode: assert property (p_xmode)
    else $error("extended bus mode flag wrong");
  property p_xspeed;
    s_pins_quiet ##0 s_rd_status ##0 pin_in.xmode
      |=> rdata[15:14] == $past(pin_in.xspeed);
  endproperty
  a_xspeed: assert property (p_xspeed)
    else $error("extended bus speed wrong");
  property p_kick;
    s_kick |=> speed_detect_start ##1 !speed_detect_start;
  endproperty
  a_kick: assert property (p_kick)
    else $error("detection start pulse missing");
  property p_kick_only;
    clk_en && !(wr_stb && addr == mdsr_pkg::ADDR_EXT_CTRL &&
                wdata[mdsr_pkg::EXT_KICK]) |=> !speed_detect_start;
  endproperty
  a_kick_only: assert property (p_kick_only)
    else $error("detection start without a kick");
endmodule

bind mdsr_top mdsr_top_monitor i_mon (
  .core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .addr(addr),
  .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
  .mac_in(mac_in), .pin_in(pin_in), .irq(irq),
  .speed_detect_start(speed_detect_start)
);

// ==== verification/test_mdsr_top.sv ====
module test_mdsr_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                      core_clk, arst_n, clk_en, wr_stb, rd_stb;
  logic                      rd_seen, speed_detect_start, irq, txp_m;
  logic [7:0]                addr, ctrl_m;
  logic [31:0]               wdata, rdata;
  logic [1:0]                spd_m, sens_m;
  mdsr_pkg::mdsr_mac_in_type mac_in, m;
  mdsr_pkg::mdsr_pin_in_type pin_in;
  logic [31:0]               exp_q[$];
  int                        fail_count, check_count, cyc;

  mdsr_top i_dut (
    .core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .mac_in(mac_in), .pin_in(pin_in), .irq(irq),
    .speed_detect_start(speed_detect_start)
  );
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] exp_status();
    logic [31:0] s;
    s = 32'h0;
    s[0] = ctrl_m[0] ? ctrl_m[1] : mac_in.an_duplex;
    s[5] = pin_in.serdes_sel & mdsr_pkg::HAS_SERDES;
    s[1] = s[5] ? ctrl_m[6] | (ctrl_m[7] & mac_in.an_link_ok)
                : mac_in.phy_link;
    s[3:2] = mdsr_pkg::FUNC_ID;
    s[4] = txp_m;
    s[7:6] = ctrl_m[3] ? ctrl_m[5:4] : ctrl_m[2] ? spd_m : mac_in.phy_speed;
    s[15:8] = {pin_in.xspeed, pin_in.xmode, pin_in.req64, pin_in.bus_66,
               1'b0, sens_m};
    return s;
  endfunction
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // Levels and pulses are judged at the falling edge, clear of the
  // rising edge that launches them
  task chk_irq(input logic e);
    @(negedge core_clk);
    check_count++;
    if (irq !== e) begin
      fail_count++;
      $display("CHECK FAILED irq expected %h seen %h", e, irq);
    end
  endtask
  task chk_start(input logic e);
    @(negedge core_clk);
    check_count++;
    if (speed_detect_start !== e) begin
      fail_count++;
      $display("CHECK FAILED speed_detect_start expected %h seen %h", e,
               speed_detect_start);
    end
  endtask
  task idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
  endtask
  // Expectation is taken when the read is issued, so inputs must be settled
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    exp_q.push_back(e);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
  endtask
  task pulse(input logic [13:0] p);
    @(posedge core_clk);
    mac_in <= mac_in | p;
    @(posedge core_clk);
    mac_in <= mac_in & ~p;
  endtask
  task complete_run();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock, monitor and timeout
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    rd_seen <= rd_stb;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      complete_run();
    end
  end
  always @(negedge core_clk) begin
    if (rd_seen)
      chk("rdata", exp_q.size() > 0 ? exp_q.pop_front() : 32'hx, rdata);
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {arst_n, wr_stb, rd_stb, rd_seen, txp_m} = '0;
    {addr, wdata, ctrl_m, spd_m, sens_m, cyc} = '0;
    {mac_in, pin_in} = '0;
    clk_en = 1'b1;
    void'($urandom(96));
    idle(4);
    arst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      m = $bits(m)'($urandom);
      mac_in <= m & 14'h3f8e;
      pin_in <= $bits(pin_in)'($urandom);
      idle(5);
      rd(8'h08, exp_status());
    end
    $display("random field test done");
    pin_in <= pin_in | 6'h20;
    mac_in <= mac_in & 14'h1fff;
    for (int s = 0; s < 4; s++) begin
      ctrl_m = {1'b1, s[0], s[1], s[0], 1'b1, 1'b0, s[1], 1'b1};
      wr(8'h00, {24'h0, ctrl_m});
      wr(8'h08, 32'hffffffff);
      idle(5);
      rd(8'h08, exp_status());
      rd(8'h00, {24'h0, ctrl_m});
    end
    $display("forced settings test done");
    ctrl_m = 8'h00;
    wr(8'h00, 32'h0);
    mac_in <= 14'h1088;
    pin_in <= 6'h1e;
    idle(5);
    wr(8'h20, 32'h7);
    wr(8'h24, 32'h2);
    idle(2);
    chk_irq(1'h0);
    for (int k = 0; k < 2; k++) begin
      pulse(14'h0040);
      txp_m = 1'b1;
      idle(3);
      rd(8'h08, exp_status());
      chk_irq(1'h1);
      pulse(k ? 14'h0010 : 14'h0020);
      txp_m = 1'b0;
      idle(3);
      rd(8'h08, exp_status());
      rd(8'h24, 32'h2);
      wr(8'h20, 32'h2);
      idle(3);
      chk_irq(1'h0);
    end
    $display("pause and interrupt test done");
    ctrl_m = 8'h04;
    wr(8'h00, 32'h4);
    mac_in <= 14'h0280;
    idle(3);
    mac_in <= 14'h1280;
    spd_m = 2'h2;
    idle(5);
    rd(8'h08, exp_status());
    mac_in <= 14'h1d80;
    idle(5);
    rd(8'h08, exp_status());
    $display("auto speed test done");
    wr(8'h18, 32'h1);
    mac_in <= mac_in | 14'h0004;
    chk_start(1'h1);
    chk_start(1'h0);
    pulse(14'h0001);
    sens_m = 2'h2;
    idle(3);
    rd(8'h08, exp_status());
    rd(8'h18, 32'h0);
    rd(8'h44, 32'h0);
    rd(8'h20, 32'h5);
    wr(8'h24, 32'h5);
    idle(2);
    chk_irq(1'h1);
    $display("sensed speed test done");
    // A sensed value offered while frozen must not be taken
    @(posedge core_clk);
    clk_en <= 1'h0;
    mac_in <= (mac_in & 14'h3ff9) | 14'h0002;
    pulse(14'h0001);
    clk_en <= 1'h1;
    idle(3);
    rd(8'h08, exp_status());
    rd(8'h20, 32'h5);
    idle(3);
    $display("clock enable test done");
    complete_run();
  end
endmodule
